//--- src/spm_pkg.sv
// shared constants of the strong pullup mode control block
package spm_pkg;
  // ------------------------------------------------------------
  // clock and bus timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int T_SLOT_US = 60;
  localparam int T_LOW1_US = 8;
  localparam int T_LOW0_US = 57;
  localparam int T_DSO_US = 3;
  localparam int T_RSTL_US = 512;
  localparam int T_PDSO_US = 70;
  localparam int T_RSTH_US = 512;
  localparam int T_SLOT_CYC = T_SLOT_US * CLK_MHZ;
  localparam int T_LOW1_CYC = T_LOW1_US * CLK_MHZ;
  localparam int T_LOW0_CYC = T_LOW0_US * CLK_MHZ;
  localparam int T_SMP_CYC = (T_LOW1_US + T_DSO_US) * CLK_MHZ;
  localparam int T_RSTL_CYC = T_RSTL_US * CLK_MHZ;
  localparam int T_PSMP_CYC = (T_RSTL_US + T_PDSO_US) * CLK_MHZ;
  localparam int T_RST_CYC = (T_RSTL_US + T_RSTH_US) * CLK_MHZ;
  // shortest pullup step, doubled per duration code
  localparam int SPU_BASE_US = 16;
  localparam int SPU_BASE_CYC = SPU_BASE_US * CLK_MHZ;
  // ------------------------------------------------------------
  // host byte codes
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_DATA_MODE = 8'h00_E1;
  localparam logic [7:0] CMD_CMD_MODE = 8'h00_E3;
  localparam logic [7:0] CMD_TERM = 8'h00_F1;
  localparam logic [7:0] RESP_PRES = 8'h00_CD;
  localparam logic [7:0] RESP_NOPRES = 8'h00_ED;
  localparam logic [7:0] RESP_PULSE = 8'h00_EC;
  localparam logic [2:0] DUR_INFINITE = 3'h7;
  // ------------------------------------------------------------
  // apb register map
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00_00;
  localparam logic [7:0] OFS_STATUS = 8'h00_04;
  localparam int CTRL_DUR_LSB = 0;
  localparam logic [2:0] CTRL_DUR_RST = 3'h4;
  localparam int ST_DATA_BIT = 0;
  localparam int ST_ARMED_BIT = 1;
  localparam int ST_SPU_BIT = 2;
  localparam int ST_HUNG_BIT = 3;
  localparam int ST_BUSY_BIT = 4;
  localparam int ST_BUF_BIT = 5;
  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    SPM_IDLE = 4'b0001,
    SPM_SLOT = 4'b0010,
    SPM_PULL = 4'b0100,
    SPM_HUNG = 4'b1000
  } spm_state_type;
  typedef enum logic [2:0] {
    SPM_OP_BYTE = 3'b001,
    SPM_OP_BIT = 3'b010,
    SPM_OP_RST = 3'b100
  } spm_op_type;
endpackage

//--- src/spm_hold_buf.sv
// one-byte holding buffer between host receiver and interpreter
`timescale 1ns/10ps
module spm_hold_buf
  import spm_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  // ------------------------------------------------------------
  // single entry; full blocks the source until drained
  // ------------------------------------------------------------
  logic full_r;
  logic [WIDTH-1:0] data_r;

  assign in_ready = !full_r;
  assign out_valid = full_r;
  assign out_data = data_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      full_r <= 1'b0;
    end else if (in_valid && !full_r) begin
      full_r <= 1'b1;
    end else if (out_ready && full_r) begin
      full_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_r <= '0;
    end else if (in_valid && !full_r) begin
      data_r <= in_data;
    end
  end
endmodule

//--- src/spm_slot_eng.sv
// single-wire time slot and reset pulse generator
`timescale 1ns/10ps
module spm_slot_eng
  import spm_pkg::*;
#(
  parameter int SLOT_CYC = T_SLOT_CYC,
  parameter int LOW1_CYC = T_LOW1_CYC,
  parameter int LOW0_CYC = T_LOW0_CYC,
  parameter int SMP_CYC = T_SMP_CYC,
  parameter int RSTL_CYC = T_RSTL_CYC,
  parameter int PSMP_CYC = T_PSMP_CYC,
  parameter int RST_CYC = T_RST_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic is_reset,
  input wire logic wbit,
  output logic done,
  output logic rbit,
  output logic busy,
  input wire logic bus_in,
  output logic bus_out,
  output logic bus_oe
);
  logic [31:0] cnt_r;
  logic [31:0] low_end;
  logic [31:0] smp_at;
  logic [31:0] end_at;
  logic busy_r;
  logic rst_r;
  logic wbit_r;
  logic rbit_r;
  logic done_r;
  logic oe_r;
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;

  // ------------------------------------------------------------
  // pin synchroniser: level follows once stages two and three agree
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      lvl_r <= 1'b1;
    end else begin
      s1_r <= bus_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        lvl_r <= s3_r;
      end
    end
  end

  assign low_end = rst_r ? 32'(RSTL_CYC) :
                   (wbit_r ? 32'(LOW1_CYC) : 32'(LOW0_CYC));
  assign smp_at = rst_r ? 32'(PSMP_CYC) : 32'(SMP_CYC);
  assign end_at = rst_r ? 32'(RST_CYC) : 32'(SLOT_CYC);

  // ------------------------------------------------------------
  // slot sequencing
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      rst_r <= 1'b0;
      wbit_r <= 1'b1;
      cnt_r <= '0;
      done_r <= 1'b0;
      rbit_r <= 1'b1;
      oe_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start && !busy_r) begin
        busy_r <= 1'b1;
        rst_r <= is_reset;
        wbit_r <= wbit;
        cnt_r <= '0;
        oe_r <= 1'b1;
      end else if (busy_r) begin
        cnt_r <= cnt_r + 32'd1;
        if (cnt_r + 32'd1 >= low_end) begin
          oe_r <= 1'b0;
        end
        // sampled level trails the pin by four cycles of synchroniser delay
        if (cnt_r == smp_at) begin
          rbit_r <= lvl_r;
        end
        if (cnt_r + 32'd1 >= end_at) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

  assign done = done_r;
  assign rbit = rbit_r;
  assign busy = busy_r;
  assign bus_out = 1'b0;
  assign bus_oe = oe_r;
endmodule

//--- src/spm_ctrl.sv
// strong pullup mode control: host byte interpreter with apb registers
//
// Contract
// - pulse command with bit 1 set arms pullup; arming persists
// - armed and in data mode, pullup follows every byte
// - after eighth slot pullup starts and data response sent together
// - end of automatic pullup sends a separate pulse response
// - unlimited duration in armed data mode hangs until reset
// - termination ends pulse, pulse response sent, none for itself
// - single-bit pullup enable comes from bit 1 of the command
// - single-bit pullup stays in command mode, any duration accepted
// - single-bit response sent at pullup start, pulse response at end
// - one host byte is buffered while the previous one executes
// - E1 enters data mode, E3 command mode, no response
// - reset command pulses bus and answers with presence or no-presence code
// - data byte sent as eight slots, sampled byte returned
// - unlimited pulse command held until termination arrives
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
module spm_ctrl
  import spm_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int SLOT_CYC = T_SLOT_CYC,
  parameter int LOW1_CYC = T_LOW1_CYC,
  parameter int LOW0_CYC = T_LOW0_CYC,
  parameter int SMP_CYC = T_SMP_CYC,
  parameter int RSTL_CYC = SLOT_CYC * T_RSTL_US / T_SLOT_US,
  parameter int PSMP_CYC = SLOT_CYC * (T_RSTL_US + T_PDSO_US) / T_SLOT_US,
  parameter int RST_CYC = SLOT_CYC * (T_RSTL_US + T_RSTH_US) / T_SLOT_US,
  parameter int SPU_BASE = SPU_BASE_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic host_valid,
  input wire logic [7:0] host_data,
  output logic host_ready,
  output logic resp_valid,
  output logic [7:0] resp_data,
  input wire logic resp_ready,
  input wire logic bus_in,
  output logic bus_out,
  output logic bus_oe,
  output logic spu_en
);
  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  spm_state_type state_r;
  spm_state_type state_nxt;
  spm_op_type op_r;
  logic cmd_valid;
  logic [7:0] cmd_byte;
  logic cmd_take;
  logic data_mode_r;
  logic armed_r;
  logic [7:0] shift_r;
  logic [7:0] shift_in;
  logic [2:0] bitcnt_r;
  logic [7:0] bitcmd_r;
  logic spu_inf_r;
  logic [31:0] spu_cnt_r;
  logic pend_pulse_r;
  logic resp_valid_r;
  logic [7:0] resp_data_r;
  logic [2:0] dur_r;
  logic eng_start;
  logic eng_reset;
  logic eng_wbit;
  logic eng_done;
  logic eng_rbit;
  logic eng_busy;
  logic is_pulse;
  logic is_reset;
  logic is_bit;
  logic free;
  logic idle_take;
  logic pull_start;
  logic pull_end;
  logic term_hit;
  logic last_bit;
  logic load_resp;
  logic [7:0] load_data;
  logic apb_acc;
  logic sel_ctrl;
  logic sel_stat;

  // ------------------------------------------------------------
  // host byte buffer and slot engine
  // ------------------------------------------------------------
  spm_hold_buf #(
    .WIDTH(8)
  ) u_buf (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(host_valid),
    .in_data(host_data),
    .in_ready(host_ready),
    .out_valid(cmd_valid),
    .out_data(cmd_byte),
    .out_ready(cmd_take)
  );

  spm_slot_eng #(
    .SLOT_CYC(SLOT_CYC),
    .LOW1_CYC(LOW1_CYC),
    .LOW0_CYC(LOW0_CYC),
    .SMP_CYC(SMP_CYC),
    .RSTL_CYC(RSTL_CYC),
    .PSMP_CYC(PSMP_CYC),
    .RST_CYC(RST_CYC)
  ) u_eng (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(eng_start),
    .is_reset(eng_reset),
    .wbit(eng_wbit),
    .done(eng_done),
    .rbit(eng_rbit),
    .busy(eng_busy),
    .bus_in(bus_in),
    .bus_out(bus_out),
    .bus_oe(bus_oe)
  );

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  assign is_pulse = (cmd_byte[7:5] == 3'b111) &&
                    (cmd_byte[3:2] == 2'b11) && cmd_byte[0];
  assign is_reset = (cmd_byte[7:4] == 4'hC) && (cmd_byte[1:0] == 2'b01);
  assign is_bit = (cmd_byte[7:5] == 3'b100) && cmd_byte[0];
  // a new byte waits until no response is outstanding
  assign free = !resp_valid_r && !pend_pulse_r;
  assign idle_take = (state_r == SPM_IDLE) && cmd_valid && free;
  // termination only counts outside data mode
  assign term_hit = (state_r == SPM_PULL) && cmd_valid && !data_mode_r &&
                    (cmd_byte == CMD_TERM);
  assign shift_in = {eng_rbit, shift_r[7:1]};
  assign last_bit = (bitcnt_r == 3'd7);
  assign pull_end = (state_r == SPM_PULL) &&
                    (term_hit || (!spu_inf_r && spu_cnt_r == 32'd0));

  always_comb begin
    cmd_take = 1'b0;
    if (idle_take || term_hit) begin
      cmd_take = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    eng_start = 1'b0;
    eng_reset = 1'b0;
    eng_wbit = 1'b1;
    pull_start = 1'b0;
    load_resp = 1'b0;
    load_data = 8'h00_00;
    case (state_r)
      SPM_IDLE: begin
        if (idle_take) begin
          if (data_mode_r && cmd_byte != CMD_CMD_MODE) begin
            eng_start = 1'b1;
            eng_wbit = cmd_byte[0];
            state_nxt = SPM_SLOT;
          end else if (!data_mode_r && is_pulse) begin
            pull_start = 1'b1;
            state_nxt = SPM_PULL;
          end else if (!data_mode_r && is_reset) begin
            eng_start = 1'b1;
            eng_reset = 1'b1;
            state_nxt = SPM_SLOT;
          end else if (!data_mode_r && is_bit) begin
            eng_start = 1'b1;
            eng_wbit = cmd_byte[4];
            state_nxt = SPM_SLOT;
          end
        end
      end
      SPM_SLOT: begin
        if (eng_done) begin
          case (op_r)
            SPM_OP_RST: begin
              load_resp = 1'b1;
              load_data = eng_rbit ? RESP_NOPRES : RESP_PRES;
              state_nxt = SPM_IDLE;
            end
            SPM_OP_BIT: begin
              load_resp = 1'b1;
              load_data = {bitcmd_r[7:2], eng_rbit, eng_rbit};
              if (bitcmd_r[1]) begin
                pull_start = 1'b1;
                state_nxt = SPM_PULL;
              end else begin
                state_nxt = SPM_IDLE;
              end
            end
            default: begin
              if (last_bit) begin
                load_resp = 1'b1;
                load_data = shift_in;
                if (armed_r && dur_r == DUR_INFINITE) begin
                  state_nxt = SPM_HUNG;
                end else if (armed_r) begin
                  pull_start = 1'b1;
                  state_nxt = SPM_PULL;
                end else begin
                  state_nxt = SPM_IDLE;
                end
              end else begin
                eng_start = 1'b1;
                eng_wbit = shift_r[1];
              end
            end
          endcase
        end
      end
      SPM_PULL: begin
        if (pull_end) begin
          state_nxt = SPM_IDLE;
        end
      end
      SPM_HUNG: begin
        state_nxt = SPM_HUNG;
      end
      default: begin
        state_nxt = SPM_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= SPM_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------
  // mode and arming
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_mode_r <= 1'b0;
      armed_r <= 1'b0;
    end else if (idle_take) begin
      if (data_mode_r && cmd_byte == CMD_CMD_MODE) begin
        data_mode_r <= 1'b0;
      end else if (!data_mode_r && cmd_byte == CMD_DATA_MODE) begin
        data_mode_r <= 1'b1;
      end else if (!data_mode_r && is_pulse) begin
        armed_r <= cmd_byte[1];
      end
    end
  end

  // ------------------------------------------------------------
  // slot operands
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      op_r <= SPM_OP_BYTE;
      shift_r <= 8'h00_00;
      bitcnt_r <= 3'd0;
      bitcmd_r <= 8'h00_00;
    end else if (idle_take) begin
      shift_r <= cmd_byte;
      bitcnt_r <= 3'd0;
      bitcmd_r <= cmd_byte;
      if (data_mode_r) begin
        op_r <= SPM_OP_BYTE;
      end else if (is_reset) begin
        op_r <= SPM_OP_RST;
      end else begin
        op_r <= SPM_OP_BIT;
      end
    end else if (state_r == SPM_SLOT && eng_done && op_r == SPM_OP_BYTE) begin
      shift_r <= shift_in;
      bitcnt_r <= bitcnt_r + 3'd1;
    end
  end

  // ------------------------------------------------------------
  // strong pullup timer
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      spu_cnt_r <= '0;
      spu_inf_r <= 1'b0;
    end else if (pull_start) begin
      // unlimited only survives in command mode; data mode hangs earlier
      spu_inf_r <= (dur_r == DUR_INFINITE);
      spu_cnt_r <= 32'(SPU_BASE) << dur_r;
    end else if (state_r == SPM_PULL && spu_cnt_r != 32'd0) begin
      spu_cnt_r <= spu_cnt_r - 32'd1;
    end
  end

  // pullup switches with the state, one cycle after the slot engine drops busy
  assign spu_en = (state_r == SPM_PULL) || (state_r == SPM_HUNG);

  // ------------------------------------------------------------
  // response path
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pend_pulse_r <= 1'b0;
    end else if (pull_end) begin
      pend_pulse_r <= 1'b1;
    end else if (pend_pulse_r && !resp_valid_r) begin
      pend_pulse_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      resp_valid_r <= 1'b0;
      resp_data_r <= 8'h00_00;
    end else if (load_resp) begin
      resp_valid_r <= 1'b1;
      resp_data_r <= load_data;
    end else if (pend_pulse_r && !resp_valid_r) begin
      resp_valid_r <= 1'b1;
      resp_data_r <= RESP_PULSE;
    end else if (resp_ready) begin
      resp_valid_r <= 1'b0;
    end
  end

  assign resp_valid = resp_valid_r;
  assign resp_data = resp_data_r;

  // ------------------------------------------------------------
  // apb registers
  // ------------------------------------------------------------
  assign apb_acc = psel && penable;
  assign sel_ctrl = (paddr == ADDR_W'(OFS_CTRL));
  assign sel_stat = (paddr == ADDR_W'(OFS_STATUS));
  assign pready = 1'b1;
  assign pslverr = apb_acc && !(sel_ctrl || (sel_stat && !pwrite));

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dur_r <= CTRL_DUR_RST;
    end else if (apb_acc && pwrite && sel_ctrl) begin
      dur_r <= pwdata[CTRL_DUR_LSB +: 3];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= '0;
      if (sel_ctrl) begin
        prdata[CTRL_DUR_LSB +: 3] <= dur_r;
      end else if (sel_stat) begin
        prdata[ST_DATA_BIT] <= data_mode_r;
        prdata[ST_ARMED_BIT] <= armed_r;
        prdata[ST_SPU_BIT] <= spu_en;
        prdata[ST_HUNG_BIT] <= (state_r == SPM_HUNG);
        prdata[ST_BUSY_BIT] <= eng_busy || (state_r != SPM_IDLE);
        prdata[ST_BUF_BIT] <= cmd_valid;
      end
    end
  end
endmodule

//--- testbench/spm_ctrl_chk.sv
// port assertions of the strong pullup control block
`timescale 1ns/10ps
module spm_ctrl_chk
  import spm_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic host_valid,
  input wire logic [7:0] host_data,
  input wire logic host_ready,
  input wire logic resp_valid,
  input wire logic [7:0] resp_data,
  input wire logic bus_out,
  input wire logic bus_oe,
  input wire logic spu_en
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic take;
  logic dm_r;
  assign take = host_valid & host_ready;
  // mode seen at the buffer input, ahead of the interpreter
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dm_r <= 1'b0;
    end else if (take &&
      host_data == (dm_r ? CMD_CMD_MODE : CMD_DATA_MODE)) begin
      dm_r <= ~dm_r;
    end
  end
  AST_PREADY_NOWAIT: assert property (psel |-> pready)
    else $error("pready low in a transfer");
  AST_UNMAPPED_ERR: assert property (psel && penable &&
    paddr != OFS_CTRL && paddr != OFS_STATUS |-> pslverr)
    else $error("no error on unmapped address");
  AST_UNMAPPED_ZERO: assert property (psel && penable && !pwrite &&
    pslverr |-> prdata == 32'h0000_0000)
    else $error("refused read gave data");
  AST_BUF_TAKES_ONE: assert property (take |=> !host_ready)
    else $error("buffer still empty after a byte");
  AST_SLOT_LOW: assert property ($rose(bus_oe) |-> bus_oe [*4])
    else $error("slot low time too short");
  AST_DRIVE_LOW: assert property (bus_oe |-> !bus_out)
    else $error("wire driven high");
  AST_SPU_EXCL: assert property (spu_en |-> !bus_oe)
    else $error("pullup while pulling low");
  AST_DATA_RESP_SPU: assert property ($rose(spu_en) && dm_r |->
    resp_valid)
    else $error("pullup without data response");
  AST_PULSE_RESP: assert property ($fell(spu_en) |->
    ##[0:2] (resp_valid && resp_data == RESP_PULSE))
    else $error("no pulse response at pullup end");
  AST_TERM_ENDS: assert property (spu_en && !dm_r && take &&
    host_data == CMD_TERM |-> ##[1:4] !spu_en)
    else $error("termination left pullup on");
  COV_SPU_END: cover property ($fell(spu_en));
  COV_DATA_SPU: cover property (dm_r && $rose(spu_en));
  COV_REFUSED: cover property (psel && penable && pslverr);
endmodule

bind spm_ctrl spm_ctrl_chk #(.ADDR_W(ADDR_W)) i_spm_ctrl_chk (
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .host_valid(host_valid), .host_data(host_data),
  .host_ready(host_ready), .resp_valid(resp_valid),
  .resp_data(resp_data), .bus_out(bus_out), .bus_oe(bus_oe),
  .spu_en(spu_en));

//--- testbench/spm_host_model.sv
// host side: sends command bytes, collects response bytes
`timescale 1ns/10ps
module spm_host_model (
  input wire logic sys_clk,
  output logic host_valid,
  output logic [7:0] host_data,
  input wire logic host_ready,
  input wire logic resp_valid,
  input wire logic [7:0] resp_data,
  output logic resp_ready
);
  logic [7:0] rq[$];
  initial begin
    host_valid = 1'b0;
    host_data = 8'h00;
    resp_ready = 1'b1;
  end
  always @(posedge sys_clk) begin
    if (resp_valid && resp_ready) begin
      rq.push_back(resp_data);
    end
  end
  // never pushes past the one-byte buffer
  task automatic send(input logic [7:0] b, output bit ok);
    int n;
    n = 0;
    @(posedge sys_clk);
    host_valid <= 1'b1;
    host_data <= b;
    // the byte is taken at the edge where host_ready is seen high
    do begin
      @(posedge sys_clk);
      n++;
    end while (host_ready !== 1'b1 && n < 3000);
    ok = (host_ready === 1'b1);
    host_valid <= 1'b0;
    // released data must not look valid
    host_data <= ~b;
  endtask
endmodule

//--- testbench/tb_top.sv
// top testbench of the strong pullup control block
`timescale 1ns/10ps
module tb_top;
  import spm_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, host_valid, host_ready, resp_valid, resp_ready;
  logic [7:0] host_data, resp_data;
  logic bus_out, bus_oe, spu_en, bus_in, er;
  int err_total = 0;
  int checked = 0;
  always #2.5 sys_clk = ~sys_clk;
  // pulled-up wire, no slave answers
  assign bus_in = bus_oe ? bus_out : 1'b1;
  // reset slot timing scales with SLOT_CYC inside the design
  spm_ctrl #(.SLOT_CYC(40), .LOW1_CYC(6), .LOW0_CYC(30), .SMP_CYC(12),
    .SPU_BASE(20))
  i_spm_ctrl (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_valid(host_valid), .host_data(host_data),
    .host_ready(host_ready), .resp_valid(resp_valid),
    .resp_data(resp_data), .resp_ready(resp_ready), .bus_in(bus_in),
    .bus_out(bus_out), .bus_oe(bus_oe), .spu_en(spu_en));
  spm_host_model i_spm_host_model (.sys_clk(sys_clk),
    .host_valid(host_valid), .host_data(host_data),
    .host_ready(host_ready), .resp_valid(resp_valid),
    .resp_data(resp_data), .resp_ready(resp_ready));
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic fail(input string what);
    err_total++;
    $display("mismatch %s exp answer got timeout", what);
    finish_test();
  endtask
  task automatic chk(input string what, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // pready, read data and error are all taken at the completing edge
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) fail("pready");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic setdur(input logic [2:0] c);
    apb(1'b1, OFS_CTRL, {29'h0, c});
  endtask
  task automatic tx(input logic [7:0] b);
    bit ok;
    i_spm_host_model.send(b, ok);
    if (!ok) fail("host_ready");
  endtask
  task automatic rx(input logic [7:0] e);
    int n;
    n = 0;
    while (i_spm_host_model.rq.size() == 0 && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    if (i_spm_host_model.rq.size() == 0) fail("resp");
    chk("resp", {24'h0, e}, {24'h0, i_spm_host_model.rq.pop_front()});
  endtask
  task automatic t_regs();
    apb(1'b0, OFS_CTRL, 0);
    chk("ctrl reset", {29'h0, CTRL_DUR_RST}, rd);
    apb(1'b0, OFS_STATUS, 0);
    chk("status reset", 0, rd);
    apb(1'b0, 8'h08, 0);
    chk("unmapped err", 1, er);
    chk("unmapped data", 0, rd);
    apb(1'b1, OFS_STATUS, 32'h0000_00FF);
    chk("status write err", 1, er);
    $display("done regs");
  endtask
  task automatic t_data();
    tx(CMD_DATA_MODE);
    tx(8'hA5);
    tx(8'h3C);
    rx(8'hA5);
    rx(8'h3C);
    tx(CMD_TERM);
    rx(CMD_TERM);
    tx(CMD_CMD_MODE);
    tx(8'hC1);
    rx(RESP_NOPRES);
    $display("done data");
  endtask
  task automatic t_bit();
    setdur(3'h1);
    tx(8'h83);
    rx(8'h80);
    chk("bit pullup", 1, spu_en);
    rx(RESP_PULSE);
    tx(8'h91);
    rx(8'h93);
    chk("bit no pullup", 0, spu_en);
    $display("done bit");
  endtask
  task automatic t_arm();
    setdur(3'h0);
    tx(8'hEF);
    tx(CMD_TERM);
    rx(RESP_PULSE);
    apb(1'b0, OFS_STATUS, 0);
    chk("armed", 1, rd[ST_ARMED_BIT]);
    tx(CMD_DATA_MODE);
    tx(8'h44);
    rx(8'h44);
    chk("byte pullup", 1, spu_en);
    rx(RESP_PULSE);
    tx(8'hFF);
    rx(8'hFF);
    rx(RESP_PULSE);
    tx(CMD_CMD_MODE);
    tx(8'hED);
    tx(CMD_TERM);
    rx(RESP_PULSE);
    apb(1'b0, OFS_STATUS, 0);
    chk("disarmed", 0, rd[ST_ARMED_BIT]);
    $display("done arm");
  endtask
  task automatic t_inf();
    setdur(DUR_INFINITE);
    tx(8'hED);
    repeat (400) @(negedge sys_clk);
    chk("pulse held", 1, spu_en);
    chk("pulse quiet", 0, i_spm_host_model.rq.size());
    tx(CMD_TERM);
    rx(RESP_PULSE);
    chk("pulse off", 0, spu_en);
    tx(8'h93);
    rx(8'h93);
    repeat (400) @(negedge sys_clk);
    chk("bit held", 1, spu_en);
    tx(CMD_TERM);
    rx(RESP_PULSE);
    $display("done unlimited");
  endtask
  task automatic t_hang();
    tx(8'hEF);
    tx(CMD_TERM);
    rx(RESP_PULSE);
    tx(CMD_DATA_MODE);
    tx(8'h55);
    rx(8'h55);
    tx(8'hAA);
    repeat (600) @(negedge sys_clk);
    chk("hung quiet", 0, i_spm_host_model.rq.size());
    apb(1'b0, OFS_STATUS, 0);
    chk("hung", 1, rd[ST_HUNG_BIT]);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    i_spm_host_model.rq.delete();
    apb(1'b0, OFS_STATUS, 0);
    chk("status after reset", 0, rd);
    tx(8'hC1);
    rx(RESP_NOPRES);
    $display("done hang");
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_data();
    t_bit();
    t_arm();
    t_inf();
    t_hang();
    finish_test();
  end
endmodule
